// >>> src/core_sfr_pkg.sv
// Constants and carrier types for the core special register set
package core_sfr_pkg;

  // Register addresses
  localparam logic [7:0] ADDR_PORT0       = 8'h80;
  localparam logic [7:0] ADDR_SP          = 8'h81;
  localparam logic [7:0] ADDR_DP0_LO      = 8'h82;
  localparam logic [7:0] ADDR_DP0_HI      = 8'h83;
  localparam logic [7:0] ADDR_DP1_LO      = 8'h84;
  localparam logic [7:0] ADDR_DP1_HI      = 8'h85;
  localparam logic [7:0] ADDR_WDT_RELOAD  = 8'h86;
  localparam logic [7:0] ADDR_UART_SPEED  = 8'h87;
  localparam logic [7:0] ADDR_TIMER_CTL   = 8'h88;
  localparam logic [7:0] ADDR_TIMER_MODE  = 8'h89;
  localparam logic [7:0] ADDR_TIMER0_LO   = 8'h8A;
  localparam logic [7:0] ADDR_TIMER1_LO   = 8'h8B;
  localparam logic [7:0] ADDR_TIMER0_HI   = 8'h8C;
  localparam logic [7:0] ADDR_TIMER1_HI   = 8'h8D;
  localparam logic [7:0] ADDR_STRETCH     = 8'h8E;
  localparam logic [7:0] ADDR_PORT1       = 8'h90;
  localparam logic [7:0] ADDR_PTR_CHOICE  = 8'h92;
  localparam logic [7:0] ADDR_SER0_CTL    = 8'h98;
  localparam logic [7:0] ADDR_SER0_BUF    = 8'h99;
  localparam logic [7:0] ADDR_IRQ_EN2     = 8'h9A;
  localparam logic [7:0] ADDR_SER1_CTL    = 8'h9B;
  localparam logic [7:0] ADDR_SER1_BUF    = 8'h9C;
  localparam logic [7:0] ADDR_SER1_REL_LO = 8'h9D;
  localparam logic [7:0] ADDR_PORT2       = 8'hA0;
  localparam logic [7:0] ADDR_IRQ_EN0     = 8'hA8;
  localparam logic [7:0] ADDR_IRQ_PRI0    = 8'hA9;
  localparam logic [7:0] ADDR_SER0_REL_LO = 8'hAA;
  localparam logic [7:0] ADDR_PORT3       = 8'hB0;
  localparam logic [7:0] ADDR_IRQ_EN1     = 8'hB8;
  localparam logic [7:0] ADDR_IRQ_PRI1    = 8'hB9;
  localparam logic [7:0] ADDR_SER0_REL_HI = 8'hBA;
  localparam logic [7:0] ADDR_SER1_REL_HI = 8'hBB;
  localparam logic [7:0] ADDR_XPAGE       = 8'hBF;
  localparam logic [7:0] ADDR_IRQ_REQ     = 8'hC0;
  localparam logic [7:0] ADDR_STATUS      = 8'hD0;
  localparam logic [7:0] ADDR_BAUD_DBL    = 8'hD8;
  localparam logic [7:0] ADDR_ACC         = 8'hE0;
  localparam logic [7:0] ADDR_MUL         = 8'hF0;

  // Reset values
  localparam logic [7:0] RST_PORT_HIGH    = 8'hFF;
  localparam logic [7:0] RST_ZERO         = 8'h00;
  localparam logic [7:0] RST_SP           = 8'h07;
  localparam logic [7:0] RST_STRETCH      = 8'h01;
  localparam logic [7:0] RST_SER0_REL_LO  = 8'hD9;
  localparam logic [7:0] RST_REL_HI       = 8'h03;
  localparam logic [15:0] RST_PC          = 16'h0000;

  // Field positions
  localparam int STATUS_CARRY     = 7;
  localparam int STATUS_HALF      = 6;
  localparam int STATUS_USER0     = 5;
  localparam int STATUS_BANK_HI   = 4;
  localparam int STATUS_BANK_LO   = 3;
  localparam int STATUS_WRAP      = 2;
  localparam int STATUS_USER1     = 1;
  localparam int STATUS_PARITY    = 0;
  localparam int BAUD_DBL_BIT     = 7;
  localparam int PTR_CHOICE_BIT   = 0;

  // Flags produced by the execution unit
  typedef struct packed {
    logic carry_bit;
    logic half_carry_bit;
    logic signed_wrap_bit;
  } alu_flags_t;

  // Direct register access from the core
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_access_t;

  // Datapath updates from the execution unit
  typedef struct packed {
    logic       acc_we;
    logic [7:0] acc_val;
    logic       mul_we;
    logic [7:0] mul_val;
    logic       flags_we;
    alu_flags_t flags;
    logic       sp_inc;
    logic       sp_dec;
    logic       data_pointer_pair_we;
    logic [15:0] data_pointer_pair_val;
    logic       data_pointer_pair_inc;
    logic       pc_inc;
    logic       pc_load;
    logic [15:0] pc_val;
  } exec_update_t;

endpackage : core_sfr_pkg

// >>> src/cpu_core_special_registers.sv
// Special function register set of the 8-bit core
// Function
// - Every listed register loads its fixed value on reset; ports 0,1,3 all ones.
// - Serial 0 reload low byte at 0xAA resets to 0xD9.
// - Both serial reload high bytes reset to 0x03.
// - Baud doubling control keeps only bit 7; other bits read zero.
// - Status bit 5 is a free software flag, never changed by hardware.
// - Bank bits 4:3 pick bank n; R0..R7 map to 8n..8n+7.
// - Status bit 0 is always the XOR of the accumulator bits.
// - Stack pointer is 8 bits and resets to 0x07.
// - Stack pointer increments before each push or call stores data.
// - Data pointer is 16 bits, loadable whole or byte by byte.
// - Data pointer addresses code table reads with accumulator and external data.
// - Program counter is 16 bits and resets to 0x0000.
// - Program counter advances on every opcode or operand fetch.
// - Multiply register holds second operand and result part; else scratch.
// - Accumulator is the implicit operand of most instructions.
// - Paged high-byte register supplies address bits 15:8 for R0/R1 accesses.
// - Pointer choice bit 0 selects first or second data pointer.
// - Unimplemented addresses read zero; writes there do nothing.
module cpu_core_special_registers
  import core_sfr_pkg::*;
(
  input  wire logic         core_clk,
  input  wire logic         rstn,
  input  wire sfr_access_t  sfr_acc,
  output logic [7:0]        sfr_rdata,
  input  wire exec_update_t exec_upd,
  input  wire logic [7:0]   ri_value,
  output logic [7:0]        acc_value,
  output logic [7:0]        mul_value,
  output logic [7:0]        status_value,
  output logic [7:0]        stack_pointer,
  output logic [7:0]        stack_write_addr,
  output logic [15:0]       data_pointer_pair,
  output logic [15:0]       code_table_addr,
  output logic [15:0]       paged_xdata_addr,
  output logic [4:0]        bank_base_addr,
  output logic [15:0]       program_counter,
  output logic [7:0]        port0_out,
  output logic [7:0]        port1_out,
  output logic [7:0]        port2_out,
  output logic [7:0]        port3_out
);

  logic [7:0] acc_reg;
  logic [7:0] mul_reg;
  logic [7:0] status_reg;
  logic [7:0] sp_reg;
  logic [7:0] dp0_lo_reg;
  logic [7:0] dp0_hi_reg;
  logic [7:0] dp1_lo_reg;
  logic [7:0] dp1_hi_reg;
  logic       ptr_sel_reg;
  logic [7:0] xpage_reg;
  logic       baud_dbl_reg;
  logic [15:0] pc_reg;
  logic [7:0] port_reg [4];
  logic [7:0] plain_reg [20];
  logic [7:0] plain_addr [20];
  logic [7:0] plain_rst [20];
  logic [15:0] data_pointer_pair_cur;
  logic [15:0] data_pointer_pair_next;
  logic [7:0] port_addr [4];
  logic [7:0] port_rst [4];

  function automatic logic wr_hit(input logic [7:0] a);
    return sfr_acc.wr && (sfr_acc.addr == a);
  endfunction

  assign port_addr = '{ADDR_PORT0, ADDR_PORT1, ADDR_PORT2, ADDR_PORT3};
  assign port_rst  = '{RST_PORT_HIGH, RST_PORT_HIGH, RST_ZERO, RST_PORT_HIGH};

  // Peripheral registers held for their own blocks
  assign plain_addr = '{ADDR_WDT_RELOAD, ADDR_UART_SPEED, ADDR_TIMER_CTL, ADDR_TIMER_MODE,
                        ADDR_TIMER0_LO, ADDR_TIMER1_LO, ADDR_TIMER0_HI, ADDR_TIMER1_HI,
                        ADDR_STRETCH, ADDR_SER0_CTL, ADDR_SER0_BUF, ADDR_IRQ_EN2,
                        ADDR_SER1_CTL, ADDR_SER1_BUF, ADDR_SER1_REL_LO, ADDR_IRQ_EN0,
                        ADDR_IRQ_PRI0, ADDR_SER0_REL_LO, ADDR_IRQ_EN1, ADDR_IRQ_PRI1};
  assign plain_rst  = '{RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                        RST_STRETCH, RST_ZERO, RST_ZERO, RST_ZERO,
                        RST_ZERO, RST_ZERO, RST_ZERO, RST_ZERO,
                        RST_ZERO, RST_SER0_REL_LO, RST_ZERO, RST_ZERO};

  logic [7:0] rel_hi_reg [2];
  logic [7:0] rel_hi_addr [2];
  logic [7:0] irq_req_reg;
  assign rel_hi_addr = '{ADDR_SER0_REL_HI, ADDR_SER1_REL_HI};

  // Ports and peripheral bytes
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!rstn) begin
        port_reg[i] <= port_rst[i];
      end else if (wr_hit(port_addr[i])) begin
        port_reg[i] <= sfr_acc.wdata;
      end
    end
    for (int i = 0; i < 20; i++) begin
      if (!rstn) begin
        plain_reg[i] <= plain_rst[i];
      end else if (wr_hit(plain_addr[i])) begin
        plain_reg[i] <= sfr_acc.wdata;
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (!rstn) begin
        rel_hi_reg[i] <= RST_REL_HI;
      end else if (wr_hit(rel_hi_addr[i])) begin
        rel_hi_reg[i] <= sfr_acc.wdata;
      end
    end
    if (!rstn) begin
      irq_req_reg <= RST_ZERO;
    end else if (wr_hit(ADDR_IRQ_REQ)) begin
      irq_req_reg <= sfr_acc.wdata;
    end
  end

  chk_rel_low_reset: assert property (@(posedge core_clk) !rstn |=>
    plain_reg[17] == 8'hD9)
    else $error("serial 0 reload low reset wrong");
  chk_rel_high_reset: assert property (@(posedge core_clk) !rstn |=>
    rel_hi_reg[0] == 8'h03 && rel_hi_reg[1] == 8'h03)
    else $error("serial reload high reset wrong");
  chk_stretch_reset: assert property (@(posedge core_clk) !rstn |=>
    plain_reg[8] == 8'h01 && port1_out == 8'hFF)
    else $error("stretch or port 1 reset wrong");
  chk_port_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_PORT2) |=> port2_out == $past(sfr_acc.wdata))
    else $error("port 2 write not visible");

  // Baud doubling, pointer choice, paged high byte
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      baud_dbl_reg <= 1'b0;
      ptr_sel_reg  <= 1'b0;
      xpage_reg    <= RST_ZERO;
    end else begin
      if (wr_hit(ADDR_BAUD_DBL)) begin
        baud_dbl_reg <= sfr_acc.wdata[BAUD_DBL_BIT];
      end
      if (wr_hit(ADDR_PTR_CHOICE)) begin
        ptr_sel_reg <= sfr_acc.wdata[PTR_CHOICE_BIT];
      end
      if (wr_hit(ADDR_XPAGE)) begin
        xpage_reg <= sfr_acc.wdata;
      end
    end
  end

  chk_baud_bits: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_BAUD_DBL) |=> baud_dbl_reg == $past(sfr_acc.wdata[BAUD_DBL_BIT]))
    else $error("baud doubling bit not stored");
  chk_baud_read: assert property (@(posedge core_clk) disable iff (!rstn)
    sfr_acc.addr == ADDR_BAUD_DBL |-> sfr_rdata[6:0] == 7'h00)
    else $error("baud doubling unused bits not zero");

  // Accumulator and multiply register
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      acc_reg <= RST_ZERO;
      mul_reg <= RST_ZERO;
    end else begin
      if (exec_upd.acc_we) begin
        acc_reg <= exec_upd.acc_val;
      end else if (wr_hit(ADDR_ACC)) begin
        acc_reg <= sfr_acc.wdata;
      end
      if (exec_upd.mul_we) begin
        mul_reg <= exec_upd.mul_val;
      end else if (wr_hit(ADDR_MUL)) begin
        mul_reg <= sfr_acc.wdata;
      end
    end
  end

  chk_acc_exec: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.acc_we |=> acc_value == $past(exec_upd.acc_val))
    else $error("accumulator update lost");
  chk_acc_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_ACC) && !exec_upd.acc_we |=> acc_value == $past(sfr_acc.wdata))
    else $error("accumulator write lost");
  chk_mul_result: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.mul_we |=> mul_value == $past(exec_upd.mul_val))
    else $error("multiply result lost");
  chk_mul_scratch: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_MUL) && !exec_upd.mul_we |=> mul_value == $past(sfr_acc.wdata))
    else $error("scratch byte write lost");

  // Status word, parity is combinational below
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      status_reg <= RST_ZERO;
    end else if (wr_hit(ADDR_STATUS)) begin
      status_reg <= sfr_acc.wdata;
    end else if (exec_upd.flags_we) begin
      status_reg[STATUS_CARRY] <= exec_upd.flags.carry_bit;
      status_reg[STATUS_HALF]  <= exec_upd.flags.half_carry_bit;
      status_reg[STATUS_WRAP]  <= exec_upd.flags.signed_wrap_bit;
    end
  end

  assign status_value = {status_reg[7:1], ^acc_reg};

  chk_user_flag_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_STATUS) |=> status_value[STATUS_USER0] == $past(sfr_acc.wdata[STATUS_USER0]))
    else $error("user flag write lost");
  chk_bank_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.flags_we && !wr_hit(ADDR_STATUS) |=> $stable(bank_base_addr))
    else $error("bank moved by flag update");

  // Stack pointer
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sp_reg <= RST_SP;
    end else if (wr_hit(ADDR_SP)) begin
      sp_reg <= sfr_acc.wdata;
    end else if (exec_upd.sp_inc) begin
      sp_reg <= sp_reg + 8'h01;
    end else if (exec_upd.sp_dec) begin
      sp_reg <= sp_reg - 8'h01;
    end
  end

  assign stack_write_addr = sp_reg + 8'h01;

  chk_stack_addr: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.sp_inc && !wr_hit(ADDR_SP) |=> stack_pointer == $past(stack_write_addr))
    else $error("push address not pre-incremented");
  chk_sp_write: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_SP) |=> stack_pointer == $past(sfr_acc.wdata))
    else $error("stack pointer write lost");

  // Data pointers
  assign data_pointer_pair_cur  = ptr_sel_reg ? {dp1_hi_reg, dp1_lo_reg} : {dp0_hi_reg, dp0_lo_reg};
  assign data_pointer_pair_next = exec_upd.data_pointer_pair_we ? exec_upd.data_pointer_pair_val : data_pointer_pair_cur + 16'h0001;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      dp0_lo_reg <= RST_ZERO;
      dp0_hi_reg <= RST_ZERO;
      dp1_lo_reg <= RST_ZERO;
      dp1_hi_reg <= RST_ZERO;
    end else if (exec_upd.data_pointer_pair_we || exec_upd.data_pointer_pair_inc) begin
      if (ptr_sel_reg) begin
        {dp1_hi_reg, dp1_lo_reg} <= data_pointer_pair_next;
      end else begin
        {dp0_hi_reg, dp0_lo_reg} <= data_pointer_pair_next;
      end
    end else begin
      if (wr_hit(ADDR_DP0_LO)) begin
        dp0_lo_reg <= sfr_acc.wdata;
      end
      if (wr_hit(ADDR_DP0_HI)) begin
        dp0_hi_reg <= sfr_acc.wdata;
      end
      if (wr_hit(ADDR_DP1_LO)) begin
        dp1_lo_reg <= sfr_acc.wdata;
      end
      if (wr_hit(ADDR_DP1_HI)) begin
        dp1_hi_reg <= sfr_acc.wdata;
      end
    end
  end

  assign data_pointer_pair = data_pointer_pair_cur;
  assign code_table_addr   = data_pointer_pair_cur + {8'h00, acc_reg};
  assign paged_xdata_addr  = {xpage_reg, ri_value};
  assign bank_base_addr    = {status_reg[STATUS_BANK_HI:STATUS_BANK_LO], 3'b000};

  chk_data_pointer_pair_load: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.data_pointer_pair_we && !wr_hit(ADDR_PTR_CHOICE) |=> data_pointer_pair == $past(exec_upd.data_pointer_pair_val))
    else $error("data pointer load lost");
  chk_data_pointer_pair_bytes: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_DP0_LO) && !exec_upd.data_pointer_pair_we && !exec_upd.data_pointer_pair_inc |=> dp0_lo_reg == $past(sfr_acc.wdata))
    else $error("data pointer byte write lost");
  chk_data_pointer_pair_inc_sel: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.data_pointer_pair_inc && !exec_upd.data_pointer_pair_we && ptr_sel_reg
    |=> {dp1_hi_reg, dp1_lo_reg} == $past({dp1_hi_reg, dp1_lo_reg}) + 16'h0001
      && {dp0_hi_reg, dp0_lo_reg} == $past({dp0_hi_reg, dp0_lo_reg}))
    else $error("wrong data pointer incremented");
  chk_table_addr: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.acc_we && !sfr_acc.wr && !exec_upd.data_pointer_pair_we && !exec_upd.data_pointer_pair_inc
    |=> code_table_addr == $past(data_pointer_pair) + {8'h00, $past(exec_upd.acc_val)})
    else $error("code table address wrong");

  // Program counter
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pc_reg <= RST_PC;
    end else if (exec_upd.pc_load) begin
      pc_reg <= exec_upd.pc_val;
    end else if (exec_upd.pc_inc) begin
      pc_reg <= pc_reg + 16'h0001;
    end
  end

  chk_pc_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    !exec_upd.pc_inc && !exec_upd.pc_load |=> $stable(pc_reg))
    else $error("program counter moved without fetch");

  // Read decode
  always_comb begin
    sfr_rdata = RST_ZERO;
    for (int i = 0; i < 4; i++) begin
      if (sfr_acc.addr == port_addr[i]) sfr_rdata = port_reg[i];
    end
    for (int i = 0; i < 20; i++) begin
      if (sfr_acc.addr == plain_addr[i]) sfr_rdata = plain_reg[i];
    end
    for (int i = 0; i < 2; i++) begin
      if (sfr_acc.addr == rel_hi_addr[i]) sfr_rdata = rel_hi_reg[i];
    end
    case (sfr_acc.addr)
      ADDR_SP:         sfr_rdata = sp_reg;
      ADDR_DP0_LO:     sfr_rdata = dp0_lo_reg;
      ADDR_DP0_HI:     sfr_rdata = dp0_hi_reg;
      ADDR_DP1_LO:     sfr_rdata = dp1_lo_reg;
      ADDR_DP1_HI:     sfr_rdata = dp1_hi_reg;
      ADDR_PTR_CHOICE: sfr_rdata = {7'h00, ptr_sel_reg};
      ADDR_XPAGE:      sfr_rdata = xpage_reg;
      ADDR_IRQ_REQ:    sfr_rdata = irq_req_reg;
      ADDR_STATUS:     sfr_rdata = status_value;
      ADDR_BAUD_DBL:   sfr_rdata = {baud_dbl_reg, 7'h00};
      ADDR_ACC:        sfr_rdata = acc_reg;
      ADDR_MUL:        sfr_rdata = mul_reg;
      default:         ;
    endcase
  end

  chk_unmapped_read: assert property (@(posedge core_clk) disable iff (!rstn)
    !sfr_acc.addr[7] |-> sfr_rdata == RST_ZERO)
    else $error("unmapped address read not zero");

  assign acc_value     = acc_reg;
  assign mul_value     = mul_reg;
  assign stack_pointer = sp_reg;
  assign program_counter = pc_reg;
  assign port0_out     = port_reg[0];
  assign port1_out     = port_reg[1];
  assign port2_out     = port_reg[2];
  assign port3_out     = port_reg[3];

  // Checks
  chk_reset_values: assert property (@(posedge core_clk) !rstn |=>
    port0_out == 8'hFF && port2_out == 8'h00 && port3_out == 8'hFF)
    else $error("port reset value wrong");
  chk_sp_reset: assert property (@(posedge core_clk) !rstn |=> sp_reg == 8'h07)
    else $error("stack pointer reset wrong");
  chk_pc_reset: assert property (@(posedge core_clk) !rstn |=> pc_reg == 16'h0000)
    else $error("program counter reset wrong");
  chk_parity_even: assert property (@(posedge core_clk) disable iff (!rstn)
    ^{acc_reg, status_value[0]} == 1'b0)
    else $error("parity flag not even");
  chk_user_flag_kept: assert property (@(posedge core_clk) disable iff (!rstn)
    !wr_hit(ADDR_STATUS) |=> $stable(status_reg[STATUS_USER0]))
    else $error("user flag changed by hardware");
  chk_sp_push: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.sp_inc && !wr_hit(ADDR_SP) |=> sp_reg == $past(sp_reg) + 8'h01)
    else $error("stack pointer did not increment");
  chk_pc_advance: assert property (@(posedge core_clk) disable iff (!rstn)
    exec_upd.pc_inc && !exec_upd.pc_load |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("program counter did not advance");
  chk_write_visible: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_XPAGE) |=> paged_xdata_addr[15:8] == $past(sfr_acc.wdata))
    else $error("paged high byte not updated");
  chk_pointer_sel: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_PTR_CHOICE) |=> data_pointer_pair ==
      ($past(sfr_acc.wdata[PTR_CHOICE_BIT]) ? {dp1_hi_reg, dp1_lo_reg} : {dp0_hi_reg, dp0_lo_reg}))
    else $error("wrong data pointer selected");
  chk_bank_base: assert property (@(posedge core_clk) disable iff (!rstn)
    wr_hit(ADDR_STATUS) |=> bank_base_addr == {$past(sfr_acc.wdata[4:3]), 3'b000})
    else $error("bank base wrong");

endmodule : cpu_core_special_registers

// >>> verification/test_cpu_core_special_registers.sv
// Self-checking bench for the core special register set
module test_cpu_core_special_registers
  import core_sfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         core_clk;
  logic         rstn;
  sfr_access_t  sfr_acc;
  exec_update_t exec_upd;
  logic [7:0]   ri_value;
  logic [7:0]   sfr_rdata, acc_value, mul_value, status_value, stack_pointer;
  logic [7:0]   stack_write_addr, port0_out, port1_out, port2_out, port3_out;
  logic [15:0]  data_pointer_pair, code_table_addr, paged_xdata_addr, program_counter;
  logic [4:0]   bank_base_addr;
  int           n_fail;
  int           comparisons;
  logic [7:0]   mdl [256];
  bit           mapped [256];
  logic [15:0]  pc_m;
  exec_update_t u;
  logic [7:0]   map_a [38] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
    8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90, 8'h92, 8'h98, 8'h99, 8'h9A,
    8'h9B, 8'h9C, 8'h9D, 8'hA0, 8'hA8, 8'hA9, 8'hAA, 8'hB0, 8'hB8, 8'hB9, 8'hBA, 8'hBB,
    8'hBF, 8'hC0, 8'hD0, 8'hD8, 8'hE0, 8'hF0};
  logic [7:0]   unm_a [6] = '{8'h91, 8'hA1, 8'hB7, 8'hC8, 8'hFF, 8'h3C};

  cpu_core_special_registers dut_u (
    .core_clk(core_clk), .rstn(rstn), .sfr_acc(sfr_acc), .sfr_rdata(sfr_rdata),
    .exec_upd(exec_upd), .ri_value(ri_value), .acc_value(acc_value),
    .mul_value(mul_value), .status_value(status_value), .stack_pointer(stack_pointer),
    .stack_write_addr(stack_write_addr), .data_pointer_pair(data_pointer_pair),
    .code_table_addr(code_table_addr), .paged_xdata_addr(paged_xdata_addr),
    .bank_base_addr(bank_base_addr), .program_counter(program_counter),
    .port0_out(port0_out), .port1_out(port1_out), .port2_out(port2_out),
    .port3_out(port3_out)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [7:0] rst_of(input logic [7:0] a);
    case (a)
      8'h80, 8'h90, 8'hB0: return 8'hFF;
      8'h81: return 8'h07;
      8'h8E: return 8'h01;
      8'hAA: return 8'hD9;
      8'hBA, 8'hBB: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] mask(input logic [7:0] a);
    case (a)
      8'h92: return 8'h01;
      8'hD8: return 8'h80;
      default: return 8'hFF;
    endcase
  endfunction

  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (a == 8'hD0) return {mdl[a][7:1], ^mdl[8'hE0]};
    return mapped[a] ? mdl[a] : 8'h00;
  endfunction

  task automatic cyc();
    ri_value = 8'($urandom);
    @(posedge core_clk);
    #1;
  endtask

  task automatic idle();
    sfr_acc.wr = 1'b0;
    exec_upd = '0;
    cyc();
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_acc = '{wr: 1'b1, addr: a, wdata: v};
    cyc();
    if (mapped[a]) mdl[a] = v & mask(a);
  endtask

  task automatic rd(input logic [7:0] a);
    sfr_acc = '{wr: 1'b0, addr: a, wdata: 8'h00};
    cyc();
    check(sfr_rdata, exp_rd(a));
  endtask

  task automatic exe(input exec_update_t x);
    logic [15:0] p;
    exec_upd = x;
    cyc();
    p = mdl[8'h92][0] ? {mdl[8'h85], mdl[8'h84]} : {mdl[8'h83], mdl[8'h82]};
    p = x.data_pointer_pair_we ? x.data_pointer_pair_val : p + 16'h0001;
    if (x.data_pointer_pair_we || x.data_pointer_pair_inc) begin
      if (mdl[8'h92][0]) {mdl[8'h85], mdl[8'h84]} = p;
      else {mdl[8'h83], mdl[8'h82]} = p;
    end
    if (x.acc_we) mdl[8'hE0] = x.acc_val;
    if (x.mul_we) mdl[8'hF0] = x.mul_val;
    if (x.flags_we) begin
      mdl[8'hD0][7] = x.flags.carry_bit;
      mdl[8'hD0][6] = x.flags.half_carry_bit;
      mdl[8'hD0][2] = x.flags.signed_wrap_bit;
    end
    if (x.sp_inc) mdl[8'h81] = mdl[8'h81] + 8'h01;
    if (x.sp_dec) mdl[8'h81] = mdl[8'h81] - 8'h01;
    if (x.pc_load) pc_m = x.pc_val;
    else if (x.pc_inc) pc_m = pc_m + 16'h0001;
  endtask

  task automatic chk_outs(input string name);
    logic [15:0] dp;
    dp = mdl[8'h92][0] ? {mdl[8'h85], mdl[8'h84]} : {mdl[8'h83], mdl[8'h82]};
    check(acc_value, mdl[8'hE0]);
    check(mul_value, mdl[8'hF0]);
    check(status_value, {mdl[8'hD0][7:1], ^mdl[8'hE0]});
    check(stack_pointer, mdl[8'h81]);
    check(stack_write_addr, 8'(mdl[8'h81] + 8'h01));
    check(data_pointer_pair, dp);
    check(code_table_addr, dp + mdl[8'hE0]);
    check(paged_xdata_addr, {mdl[8'hBF], ri_value});
    check(bank_base_addr, {mdl[8'hD0][4:3], 3'b000});
    check(program_counter, pc_m);
    check({port0_out, port1_out}, {mdl[8'h80], mdl[8'h90]});
    check({port2_out, port3_out}, {mdl[8'hA0], mdl[8'hB0]});
    $display("test %s done", name);
  endtask

  task automatic do_reset(input int n);
    rstn = 1'b0;
    sfr_acc = '0;
    exec_upd = '0;
    repeat (n) cyc();
    rstn = 1'b1;
    for (int i = 0; i < 256; i++) begin
      mapped[i] = 1'b0;
      mdl[i] = 8'h00;
    end
    foreach (map_a[j]) begin
      mapped[map_a[j]] = 1'b1;
      mdl[map_a[j]] = rst_of(map_a[j]);
    end
    pc_m = 16'h0000;
    cyc();
    foreach (map_a[j]) rd(map_a[j]);
    chk_outs("reset");
  endtask

  initial begin
    #900000;
    n_fail++;
    stop_test();
  end

  initial begin
    void'($urandom(20));
    do_reset(20);
    foreach (map_a[j]) wr(map_a[j], 8'($urandom));
    foreach (unm_a[j]) wr(unm_a[j], 8'($urandom));
    idle();
    foreach (map_a[j]) rd(map_a[j]);
    foreach (unm_a[j]) rd(unm_a[j]);
    chk_outs("bus access");
    for (int k = 0; k < 4; k++) begin
      wr(8'hD0, 8'(k * 8 + (k % 2) * 32) | 8'h01);
      idle();
      u = '0;
      u.flags_we = 1'b1;
      u.flags = 3'($urandom);
      exe(u);
      idle();
      rd(8'hD0);
      chk_outs("status word");
    end
    wr(8'h81, 8'hFE);
    idle();
    u = '0;
    u.sp_inc = 1'b1;
    for (int k = 0; k < 3; k++) begin
      exe(u);
      idle();
      chk_outs("stack push");
    end
    u = '0;
    u.sp_dec = 1'b1;
    exe(u);
    idle();
    chk_outs("stack pop");
    for (int k = 0; k < 2; k++) begin
      wr(8'h92, 8'hFE | 8'(k));
      idle();
      chk_outs("pointer choice");
      u = '0;
      u.data_pointer_pair_we = 1'b1;
      u.data_pointer_pair_val = (k == 0) ? 16'hFFFF : 16'($urandom);
      exe(u);
      u = '0;
      u.data_pointer_pair_inc = 1'b1;
      exe(u);
      idle();
      foreach (map_a[j]) rd(map_a[j]);
      chk_outs("pointer update");
    end
    u = '0;
    u.acc_we = 1'b1;
    u.acc_val = 8'($urandom);
    u.mul_we = 1'b1;
    u.mul_val = 8'($urandom);
    sfr_acc = '{wr: 1'b1, addr: 8'hE0, wdata: ~u.acc_val};
    exe(u);
    idle();
    chk_outs("exec operands");
    u = '0;
    u.sp_inc = 1'b1;
    u.flags_we = 1'b1;
    u.flags = 3'b111;
    sfr_acc = '{wr: 1'b1, addr: 8'h81, wdata: 8'h40};
    exe(u);
    mdl[8'h81] = 8'h40;
    sfr_acc = '{wr: 1'b1, addr: 8'hD0, wdata: 8'h00};
    exe(u);
    mdl[8'hD0] = 8'h00;
    idle();
    u = '0;
    u.acc_we = 1'b1;
    u.acc_val = 8'($urandom);
    exe(u);
    idle();
    rd(8'hD0);
    chk_outs("write priority");
    u = '0;
    u.pc_inc = 1'b1;
    repeat (5) exe(u);
    u.pc_load = 1'b1;
    u.pc_val = 16'($urandom);
    exe(u);
    u.pc_load = 1'b0;
    exe(u);
    idle();
    chk_outs("program counter");
    do_reset(2);
    stop_test();
  end

endmodule // test_cpu_core_special_registers
